// ==== hdl/pti_timebase.sv ====
// Timebase top: Avalon-MM control register, pending flag and requests
`timescale 1ns/10ps
module pti_timebase #(
  parameter int STAGES  = pti_pkg::PTI_STAGES,
  parameter int REF_DIV = pti_pkg::PTI_REF_DIV_CYC
) (
  input  wire logic                          clock,
  input  wire logic                          arst_n,
  input  wire logic [pti_pkg::PTI_ADDR_W-1:0] avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [pti_pkg::PTI_DATA_W-1:0] avs_writedata,
  input  wire logic [pti_pkg::PTI_BE_W-1:0]   avs_byteenable,
  output logic [pti_pkg::PTI_DATA_W-1:0]      avs_readdata,
  output logic                               avs_waitrequest,
  input  wire logic                          wait_mode,
  input  wire logic                          stop_mode,
  input  wire logic                          stop_osc_enable,
  output logic                               irq,
  output logic                               stop_wakeup,
  output logic                               counter_running
);
  import pti_pkg::*;

  typedef enum logic [0:0] {
    PTI_BUS_IDLE,
    PTI_BUS_ANSWER
  } pti_bus_state_t;

  pti_bus_state_t bus_state_r;
  pti_bus_state_t bus_state_nxt;

  pti_ctrl_t ctrl_r;
  pti_ctrl_t ctrl_nxt;

  logic flag_r;
  logic flag_nxt;

  // Bus decode
  logic request;
  logic hit;
  logic lane0;
  logic locked;
  logic accept;
  logic wr_take;
  logic wr_ctrl;
  logic ack_write;
  logic [PTI_REG_W-1:0] wbyte;
  logic [PTI_REG_W-1:0] ctrl_view;
  logic [PTI_DATA_W-1:0] rd_word;
  logic [PTI_DATA_W-1:0] readdata_nxt;

  // Timebase datapath
  logic ref_tick;
  logic advance_ok;
  logic rollover;
  logic irq_nxt;
  logic wakeup_nxt;
  logic running_nxt;

  // ---------------------------------------------------------------
  // Reference tick and divider chain
  // ---------------------------------------------------------------

  pti_ref_divider #(
    .DIV      (REF_DIV)
  ) u_ref_div (
    .clock    (clock),
    .arst_n   (arst_n),
    .ref_tick (ref_tick)
  );

  // [RL13] stop gating
  assign advance_ok = ~stop_mode | stop_osc_enable;

  // [RL1] divider chain
  pti_divider_chain #(
    .STAGES      (STAGES)
  ) u_chain (
    .clock       (clock),
    .arst_n      (arst_n),
    .ref_tick    (ref_tick),
    .enable      (ctrl_r.timebase_enable),
    .advance_ok  (advance_ok),
    .rate_select (ctrl_r.rate_select),
    .rollover    (rollover)
  );

  // ---------------------------------------------------------------
  // Avalon-MM slave, one wait state per access
  // ---------------------------------------------------------------

  assign request = avs_read | avs_write;
  assign hit     = (avs_address[PTI_ADDR_W-1:2] == PTI_CTRL_OFFSET[PTI_ADDR_W-1:2]);
  assign lane0   = avs_byteenable[0];

  // [RL12] locked in low power
  assign locked  = wait_mode | stop_mode;

  // A locked access is still answered so the master never hangs
  assign accept  = request & (bus_state_r == PTI_BUS_IDLE);

  // Write lands at the edge that sees waitrequest low
  assign wr_take = avs_write & (bus_state_r == PTI_BUS_ANSWER);
  assign wr_ctrl = wr_take & hit & lane0 & ~locked;
  assign wbyte   = avs_writedata[PTI_REG_W-1:0];

  // [RL6] acknowledge by one
  assign ack_write = wr_ctrl & wbyte[PTI_ACK_BIT];

  always_comb begin
    bus_state_nxt = bus_state_r;
    case (bus_state_r)
      PTI_BUS_IDLE: begin
        if (accept) begin
          bus_state_nxt = PTI_BUS_ANSWER;
        end
      end
      PTI_BUS_ANSWER: begin
        bus_state_nxt = PTI_BUS_IDLE;
      end
      default: begin
        bus_state_nxt = PTI_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bus_state_r <= PTI_BUS_IDLE;
    end else begin
      bus_state_r <= bus_state_nxt;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~accept;
    end
  end

  // ---------------------------------------------------------------
  // Register view and read data
  // ---------------------------------------------------------------

  // [RL6] acknowledge reads zero
  always_comb begin
    ctrl_view                                      = PTI_CTRL_RESET;
    ctrl_view[PTI_FLAG_BIT]                        = flag_r;
    ctrl_view[PTI_RATE_LSB +: PTI_RATE_W]          = ctrl_r.rate_select;
    ctrl_view[PTI_ACK_BIT]                         = 1'b0;
    ctrl_view[PTI_IE_BIT]                          = ctrl_r.rollover_irq_enable;
    ctrl_view[PTI_EN_BIT]                          = ctrl_r.timebase_enable;
  end

  // Unmapped or locked reads return zero
  assign rd_word = {{(PTI_DATA_W-PTI_REG_W){1'b0}}, ctrl_view};

  assign readdata_nxt = (accept & avs_read & hit & ~locked) ? rd_word : '0;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= '0;
    end else if (accept) begin
      avs_readdata <= readdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------

  // Rate is taken as written even when enabled; software is expected
  // to disable first, otherwise the first period after the change is short
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt.rate_select         = wbyte[PTI_RATE_LSB +: PTI_RATE_W];
      ctrl_nxt.rollover_irq_enable = wbyte[PTI_IE_BIT];
      ctrl_nxt.timebase_enable     = wbyte[PTI_EN_BIT];
    end
  end

  // [RL11] reset clears enables
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= PTI_CTRL_INIT;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Pending flag
  // ---------------------------------------------------------------

  // [RL7] no direct write
  // [RL15] sticky, set wins
  always_comb begin
    flag_nxt = flag_r;
    if (rollover) begin
      flag_nxt = 1'b1;
    end else if (ack_write) begin
      flag_nxt = 1'b0;
    end
  end

  // [RL4] set on rollover
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Requests and status outputs
  // ---------------------------------------------------------------

  // [RL5] level interrupt
  assign irq_nxt = flag_nxt & ctrl_nxt.rollover_irq_enable;

  // [RL14] stop wake-up
  assign wakeup_nxt = irq_nxt & stop_mode & stop_osc_enable;

  assign running_nxt = ctrl_nxt.timebase_enable & advance_ok;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_nxt;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stop_wakeup <= 1'b0;
    end else begin
      stop_wakeup <= wakeup_nxt;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      counter_running <= 1'b0;
    end else begin
      counter_running <= running_nxt;
    end
  end

endmodule

// ==== shared/pti_pkg.sv ====
// Constants, field layout and carrier types of the periodic timebase block
// Overview of operation
// [RL1] Eighteen divider stages, eight selectable taps
// [RL2] Counter held at zero while disabled
// [RL3] Counter advances on reference ticks when enabled
// [RL4] Selected tap rollover sets pending flag
// [RL5] Interrupt request when flag and enable
// [RL6] Acknowledge one clears flag, reads zero
// [RL7] Pending flag is read-only to software
// [RL8] First flag at half period, then full
// [RL9] Rate select decodes to eight dividers
// [RL10] Software keeps rate fixed while enabled
// [RL11] Reset clears interrupt and timebase enables
// [RL12] Wait mode counts on, register locked
// [RL13] Stop mode runs only with oscillator kept
// [RL14] Stop-mode rollover raises wake-up request
// [RL15] Flag sticky; request is a level
package pti_pkg;

  // Bus geometry
  localparam int          PTI_ADDR_W       = 4;
  localparam int          PTI_DATA_W       = 32;
  localparam int          PTI_BE_W         = 4;
  localparam int          PTI_REG_W        = 8;
  localparam logic [3:0]  PTI_CTRL_OFFSET  = 4'h0;

  // Field positions of timebase_control
  localparam int          PTI_FLAG_BIT     = 7;
  localparam int          PTI_RATE_LSB     = 4;
  localparam int          PTI_RATE_W       = 3;
  localparam int          PTI_ACK_BIT      = 3;
  localparam int          PTI_IE_BIT       = 2;
  localparam int          PTI_EN_BIT       = 1;
  localparam logic [7:0]  PTI_CTRL_RESET   = 8'h00;

  // Divider chain
  localparam int          PTI_STAGES       = 18;
  localparam int          PTI_TAP_IDX_W    = 5;
  // Tap bit per rate: 262144, 131072, 65536, 32768, 64, 32, 16, 8.
  // A tap bit rises at half the divider, then once per divider.
  localparam logic [7:0][4:0] PTI_TAP_BIT = {
    5'h02, 5'h03, 5'h04, 5'h05, 5'h0e, 5'h0f, 5'h10, 5'h11
  };

  // Timing: 200 MHz system clock, 4 MHz reference oscillator
  localparam int          PTI_CLK_PERIOD_PS = 5000;
  localparam int          PTI_REF_PERIOD_PS = 250000;
  localparam int          PTI_REF_DIV_CYC   = PTI_REF_PERIOD_PS / PTI_CLK_PERIOD_PS;
  localparam int          PTI_REF_CNT_W     = 8;

  typedef struct packed {
    logic [2:0] rate_select;
    logic       rollover_irq_enable;
    logic       timebase_enable;
  } pti_ctrl_t;

  localparam pti_ctrl_t   PTI_CTRL_INIT = '{rate_select: 3'h0,
                                            rollover_irq_enable: 1'b0,
                                            timebase_enable: 1'b0};

endpackage

// ==== hdl/pti_ref_divider.sv ====
// Reference oscillator tick generator from the system clock
`timescale 1ns/10ps
module pti_ref_divider #(
  parameter int DIV = pti_pkg::PTI_REF_DIV_CYC
) (
  input  wire logic clock,
  input  wire logic arst_n,
  output logic      ref_tick
);
  import pti_pkg::*;

  logic [PTI_REF_CNT_W-1:0] cnt_r;
  logic [PTI_REF_CNT_W-1:0] cnt_nxt;
  logic                     wrap;

  localparam logic [PTI_REF_CNT_W-1:0] LAST = PTI_REF_CNT_W'(DIV - 1);

  assign wrap    = (cnt_r == LAST);
  assign cnt_nxt = wrap ? '0 : cnt_r + 1'b1;

  // Oscillator runs freely; gating is done by the consumer
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r    <= '0;
      ref_tick <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      ref_tick <= wrap;
    end
  end

endmodule

// ==== hdl/pti_divider_chain.sv ====
// Eighteen-stage binary divider with selectable rollover tap
`timescale 1ns/10ps
module pti_divider_chain #(
  parameter int STAGES = pti_pkg::PTI_STAGES
) (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       ref_tick,
  input  wire logic       enable,
  input  wire logic       advance_ok,
  input  wire logic [2:0] rate_select,
  output logic            rollover
);
  import pti_pkg::*;

  logic [STAGES-1:0]        cnt_r;
  logic [STAGES-1:0]        cnt_nxt;
  logic [PTI_TAP_IDX_W-1:0] tap;
  logic                     step;
  logic                     tap_rise;

  // [RL9] rate to tap
  function automatic logic [PTI_TAP_IDX_W-1:0] tap_of(input logic [2:0] sel);
    tap_of = PTI_TAP_BIT[sel];
  endfunction

  assign tap      = tap_of(rate_select);
  // [RL3] advance on ticks
  assign step     = enable & advance_ok & ref_tick;
  assign cnt_nxt  = cnt_r + 1'b1;
  // [RL8] tap rising edge
  assign tap_rise = step & ~cnt_r[tap] & cnt_nxt[tap];

  // [RL2] hold zero disabled
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
    end else if (!enable) begin
      cnt_r <= '0;
    end else if (step) begin
      cnt_r <= cnt_nxt;
    end
  end

  // [RL4] rollover pulse
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rollover <= 1'b0;
    end else begin
      rollover <= tap_rise;
    end
  end

endmodule

// ==== verif/pti_timebase_properties.sv ====
// Concurrent checks on the timebase top ports
`timescale 1ns/10ps
module pti_timebase_properties (
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        wait_mode,
  input wire logic        stop_mode,
  input wire logic        stop_osc_enable,
  input wire logic        irq,
  input wire logic        stop_wakeup,
  input wire logic        counter_running
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Write that really lands in the control register
  wire acc_ok = avs_write && !avs_waitrequest && avs_byteenable[0]
                && avs_address[3:2] == 2'h0 && !wait_mode && !stop_mode;

  chk_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  chk_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_rd_hold: assert property (avs_waitrequest |-> $stable(avs_readdata))
    else $error("read data moved outside an access");
  chk_rd_fixed: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0
    && avs_readdata[3] == 1'b0 && avs_readdata[0] == 1'b0)
    else $error("fixed-zero read bits not zero");
  chk_lock_read: assert property (avs_read && avs_waitrequest && (wait_mode || stop_mode)
    |=> avs_readdata == 32'h0)
    else $error("locked register returned data");
  chk_stop_gate: assert property (stop_mode && !stop_osc_enable |=> !counter_running)
    else $error("counter runs in stop without oscillator");
  chk_wake_cause: assert property (stop_wakeup |-> irq && $past(stop_mode)
    && $past(stop_osc_enable))
    else $error("wake-up without cause");
  chk_wake_set: assert property (irq && stop_mode && stop_osc_enable |=> stop_wakeup)
    else $error("wake-up missing");
  chk_ie_off: assert property (acc_ok && !avs_writedata[2] |-> ##2 !irq)
    else $error("irq with interrupt enable clear");
  chk_en_off: assert property (acc_ok && !avs_writedata[1] |-> ##2 !counter_running)
    else $error("counter running after disable");
endmodule

// ==== verif/pti_timebase_tb.sv ====
// Self-checking bench for the periodic timebase top
`timescale 1ns/10ps
module pti_timebase_tb;
  import pti_pkg::*;
  localparam int RD = 2;
  logic        clock, arst_n, avs_read, avs_write, wait_mode, stop_mode, stop_osc_enable;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        avs_waitrequest, irq, stop_wakeup, counter_running;
  int          bad_count, total_checks, cyc, t0, t1, t2, d;

  pti_timebase #(.REF_DIV(RD)) dut_u (.clock(clock), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .stop_osc_enable(stop_osc_enable),
    .irq(irq), .stop_wakeup(stop_wakeup), .counter_running(counter_running));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Fields: flag, rate, acknowledge, irq enable, timebase enable
  function automatic logic [31:0] ctl(input logic [2:0] r, input logic k, ie, en, f);
    return {24'h0, f, r, k, ie, en, 1'b0};
  endfunction

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clock);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be;
    // Held until an edge samples waitrequest low; only the global timeout ends it
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    check(n, 2);
  endtask

  task automatic wr(input logic [31:0] v);
    bus(1'b1, 4'h0, v, 4'h1);
  endtask

  task automatic rdc(input logic [31:0] exp);
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    check(rd, exp);
  endtask

  task automatic wait_irq(output int t);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (irq !== 1'b1 && n < 5000);
    t = cyc;
  endtask

  task automatic t_fields();
    rdc(ctl(3'h0, 1'b0, 1'b0, 1'b0, 1'b0));
    check(counter_running, 1'b0);
    for (int r = 0; r < 8; r++) begin
      wr(ctl(3'(r), 1'b1, 1'b1, 1'b0, 1'b1) | 32'h1);
      rdc(ctl(3'(r), 1'b0, 1'b1, 1'b0, 1'b0));
    end
    bus(1'b1, 4'h4, 32'h0, 4'h1);
    bus(1'b0, 4'h4, 32'h0, 4'hf);
    check(rd, 32'h0);
    bus(1'b1, 4'h0, 32'h0, 4'h0);
    rdc(ctl(3'h7, 1'b0, 1'b1, 1'b0, 1'b0));
  endtask

  task automatic t_period();
    for (int r = 4; r < 8; r++) begin
      d = 8 << (7 - r);
      wr(ctl(3'(r), 1'b1, 1'b1, 1'b0, 1'b0));
      wr(ctl(3'(r), 1'b0, 1'b1, 1'b1, 1'b0));
      t0 = cyc;
      wait_irq(t1);
      check(32'(t1 - t0 >= d * RD / 2 && t1 - t0 <= d * RD / 2 + 8), 1);
      wr(ctl(3'(r), 1'b1, 1'b1, 1'b1, 1'b0));
      wait_irq(t2);
      check(t2 - t1, d * RD);
      wr(ctl(3'(r), 1'b0, 1'b1, 1'b0, 1'b0));
    end
  endtask

  task automatic t_sticky();
    wr(ctl(3'h7, 1'b1, 1'b0, 1'b1, 1'b0));
    repeat (60) @(negedge clock);
    check(irq, 1'b0);
    rdc(ctl(3'h7, 1'b0, 1'b0, 1'b1, 1'b1));
    wr(ctl(3'h7, 1'b0, 1'b1, 1'b1, 1'b0));
    repeat (40) @(negedge clock);
    check(irq, 1'b1);
    wr(ctl(3'h7, 1'b0, 1'b1, 1'b0, 1'b0));
    @(negedge clock);
    check(counter_running, 1'b0);
    rdc(ctl(3'h7, 1'b0, 1'b1, 1'b0, 1'b1));
    check(irq, 1'b1);
    wr(ctl(3'h7, 1'b1, 1'b1, 1'b0, 1'b0));
    rdc(ctl(3'h7, 1'b0, 1'b1, 1'b0, 1'b0));
    check(irq, 1'b0);
  endtask

  task automatic t_modes();
    wr(ctl(3'h7, 1'b1, 1'b1, 1'b1, 1'b0));
    wait_mode <= 1'b1;
    rdc(32'h0);
    wr(32'h0);
    wait_irq(t1);
    check(irq, 1'b1);
    wait_mode <= 1'b0;
    rdc(ctl(3'h7, 1'b0, 1'b1, 1'b1, 1'b1));
    wr(ctl(3'h7, 1'b1, 1'b1, 1'b1, 1'b0));
    stop_mode <= 1'b1;
    repeat (3) @(negedge clock);
    check(counter_running, 1'b0);
    check(stop_wakeup, 1'b0);
    rdc(32'h0);
    @(posedge clock);
    stop_osc_enable <= 1'b1;
    repeat (40) @(negedge clock);
    check(counter_running, 1'b1);
    check(stop_wakeup, 1'b1);
    @(posedge clock);
    stop_mode <= 1'b0;
    repeat (3) @(negedge clock);
    check(stop_wakeup, 1'b0);
  endtask

  task automatic t_reset();
    wr(ctl(3'h7, 1'b0, 1'b1, 1'b1, 1'b0));
    repeat (20) @(posedge clock);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    @(negedge clock);
    check({irq, stop_wakeup, counter_running, avs_waitrequest}, 4'h1);
    rdc(32'h0);
    check(counter_running, 1'b0);
  endtask

  initial begin
    {arst_n, avs_read, avs_write, wait_mode, stop_mode, stop_osc_enable} = '0;
    {avs_address, avs_byteenable, avs_writedata} = '0;
    {bad_count, total_checks, cyc} = '0;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    t_fields();
    t_period();
    t_sticky();
    t_modes();
    t_reset();
    test_done();
  end
endmodule

bind pti_timebase pti_timebase_properties chk_u (.clock(clock), .arst_n(arst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .wait_mode(wait_mode), .stop_mode(stop_mode), .stop_osc_enable(stop_osc_enable),
  .irq(irq), .stop_wakeup(stop_wakeup), .counter_running(counter_running));
